// ==== verilog/cfc_pkg.sv ====
// constants, types and contract of the filter control register bank
// Contract
// RQ1 - Two 32-bit control words exist, filters 8-11 in the first and 12-15 in the second, one per byte, highest filter on top.
// RQ2 - In the first word filter 11 has enable at bit 31, mask choice at 30-29 and fifo choice at 28-24.
// RQ3 - Filters 10, 9 and 8 sit in bytes 2, 1 and 0 of the first word with the same enable, mask, fifo order.
// RQ4 - The second word holds filters 15 down to 12 in the same per-byte layout, filter 15 on top.
// RQ5 - An enable bit of one puts its filter into acceptance and zero takes it out.
// RQ6 - The two-bit mask choice picks acceptance mask 0 to 3 by its binary value.
// RQ7 - The five-bit fifo choice names destination fifo 0 to 31 by its binary value.
// RQ8 - Every bit of both words is readable and writable and resets to zero, all filters off.
// RQ9 - A write to the word's address plus 0x4 clears the bits where the data has ones.
// RQ10 - A write to the word's address plus 0x8 sets the bits where the data has ones.
// RQ11 - A write to the word's address plus 0xC toggles the bits where the data has ones.
// RQ12 - Software ignores what the alias addresses read and reads a word only at its base.
// RQ13 - Mask and fifo choice of a filter change only while its enable is zero, else the change is blocked.
// RQ14 - The enable bit is writable at all times so a filter can be stopped, changed and restarted.
// RQ15 - Each filter's enable, mask and fifo choice are outputs that follow a write at the next edge.
package cfc_pkg;
  localparam int NUM_FILT = 8;
  localparam int LANES = 4;
  localparam int ADDR_W = 6;
  localparam int DATA_W = 32;
  // address map, byte addresses
  localparam logic [ADDR_W-1:0] OFS_CTRL_8_TO_11 = 6'h00;
  localparam logic [ADDR_W-1:0] OFS_CTRL_12_TO_15 = 6'h10;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 6'h20;
  localparam int WSEL_LSB = 4;
  localparam int OP_LSB = 2;
  // per-lane field layout
  localparam int ON_BIT = 7;
  localparam int MASK_LSB = 5;
  localparam int FIFO_LSB = 0;
  localparam logic [7:0] LANE_FIELDS = 8'h7F;
  // status word layout
  localparam int STAT_BLK_LSB = 8;
  localparam logic [DATA_W-1:0] WORD_RESET = 32'h00000000;
  localparam logic [1:0] BLK_RESET = 2'h0;
  // alias operation, from address bits 3:2
  typedef enum logic [1:0] {
    OP_WR = 2'b00,
    OP_CLR = 2'b01,
    OP_SET = 2'b10,
    OP_INV = 2'b11
  } cfc_op_t;
  // one filter's byte, top bit first
  typedef struct packed {
    logic on;
    logic [1:0] mask_choice;
    logic [4:0] dest_fifo_choice;
  } cfc_filt_t;
  localparam cfc_filt_t FILT_RESET = 8'h00;
endpackage : cfc_pkg

// ==== verilog/cfc_regs.sv ====
// filter control registers for filters 8 to 15 on an avalon-mm slave
//
// Chosen here: the register addresses and the Avalon-MM slave port.
`timescale 1ns/10ps
`default_nettype none
module cfc_regs
  import cfc_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // avalon-mm slave
  input wire logic [ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [DATA_W-1:0] writedata,
  input wire logic [LANES-1:0] byteenable,
  output logic [DATA_W-1:0] readdata,
  output logic waitrequest,
  // per-filter settings to acceptance matching
  output cfc_filt_t [NUM_FILT-1:0] filt_cfg
);

  // alias operation on one filter byte
  function automatic logic [7:0] apply_op(
    input logic [7:0] old_v,
    input logic [7:0] wd,
    input cfc_op_t op
  );
    logic [7:0] res;
    res = wd;
    unique case (op)
      OP_WR: res = wd;
      OP_CLR: res = old_v & ~wd; // RQ9
      OP_SET: res = old_v | wd; // RQ10
      OP_INV: res = old_v ^ wd; // RQ11
    endcase
    return res;
  endfunction : apply_op

  logic ack_r;
  logic [DATA_W-1:0] rdata_r;
  cfc_filt_t [NUM_FILT-1:0] cfg_r;
  cfc_filt_t [NUM_FILT-1:0] cfg_nxt;
  logic [1:0] blk_r;
  logic [1:0] blk_nxt;

  // bus handshake: every access waits exactly one cycle
  wire req;
  wire wr_acc;
  wire rd_cap;
  assign req = read | write;
  assign wr_acc = write & ack_r;
  assign rd_cap = read & ~ack_r;
  assign waitrequest = req & ~ack_r;

  // address decode; misaligned or unmapped reads give zero
  wire aligned;
  wire [1:0] word_sel;
  cfc_op_t op;
  wire [1:0] hit_ctrl;
  wire hit_stat;
  assign aligned = (address[OP_LSB-1:0] == 2'h0);
  assign word_sel = address[ADDR_W-1:WSEL_LSB];
  assign op = cfc_op_t'(address[WSEL_LSB-1:OP_LSB]);
  assign hit_ctrl[0] = aligned && (word_sel == OFS_CTRL_8_TO_11[ADDR_W-1:WSEL_LSB]);
  assign hit_ctrl[1] = aligned && (word_sel == OFS_CTRL_12_TO_15[ADDR_W-1:WSEL_LSB]);
  assign hit_stat = (address == OFS_STATUS);

  // per-filter update with the lock on mask and fifo fields
  wire [NUM_FILT-1:0] blocked;
  wire [NUM_FILT-1:0] on_vec;
  genvar f;
  generate
    for (f = 0; f < NUM_FILT; f++) begin : g_filt
      wire [7:0] wd_lane;
      wire lane_we;
      wire locked;
      wire [7:0] prop;
      assign wd_lane = writedata[(f % LANES) * $bits(cfc_filt_t) +: $bits(cfc_filt_t)]; // RQ1 RQ3 RQ4
      assign lane_we = wr_acc & hit_ctrl[f / LANES] & byteenable[f % LANES];
      assign locked = cfg_r[f].on;
      assign prop = apply_op(cfg_r[f], wd_lane, op);
      // enable stays writable so a locked filter can be released
      assign cfg_nxt[f].on = lane_we ? prop[ON_BIT] : cfg_r[f].on; // RQ14 RQ5
      // fields judged against the enable held before this write
      assign cfg_nxt[f][ON_BIT-1:0] = (lane_we && !locked) ? prop[ON_BIT-1:0]
                                      : cfg_r[f][ON_BIT-1:0]; // RQ13 RQ6 RQ7
      assign blocked[f] = lane_we && locked
                          && ((prop & LANE_FIELDS) != (cfg_r[f] & LANE_FIELDS)); // RQ13
      assign on_vec[f] = cfg_r[f].on;
    end
  endgenerate

  // blocked-change flags: write one clears, a new block wins
  wire [1:0] blk_set;
  wire [1:0] blk_clr;
  assign blk_set[0] = |blocked[LANES-1:0];
  assign blk_set[1] = |blocked[NUM_FILT-1:LANES];
  assign blk_clr = (wr_acc && hit_stat && byteenable[1]) ? writedata[STAT_BLK_LSB +: 2] : 2'h0;
  assign blk_nxt = (blk_r & ~blk_clr) | blk_set;

  // read mux; alias addresses read zero, their value has no meaning
  wire [DATA_W-1:0] word0;
  wire [DATA_W-1:0] word1;
  wire [DATA_W-1:0] stat_word;
  wire [DATA_W-1:0] rd_mux;
  assign word0 = cfg_r[LANES-1:0]; // RQ1 RQ2 RQ3
  assign word1 = cfg_r[NUM_FILT-1:LANES]; // RQ4
  assign stat_word = {22'h000000, blk_r, on_vec};
  assign rd_mux = (hit_ctrl[0] && op == OP_WR) ? word0 :
                  (hit_ctrl[1] && op == OP_WR) ? word1 :
                  hit_stat ? stat_word : WORD_RESET; // RQ8

  // handshake and read data capture
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ack_r <= 1'b0;
      rdata_r <= WORD_RESET;
    end else begin
      ack_r <= req & ~ack_r;
      if (rd_cap) begin
        rdata_r <= rd_mux;
      end
    end
  end

  // control words, all filters off after reset
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cfg_r <= {NUM_FILT{FILT_RESET}}; // RQ8
      blk_r <= BLK_RESET;
    end else begin
      cfg_r <= cfg_nxt; // RQ15
      blk_r <= blk_nxt;
    end
  end

  assign readdata = rdata_r;
  assign filt_cfg = cfg_r; // RQ15

  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  wire wr_plain0;
  wire wr_plain1;
  assign wr_plain0 = wr_acc && hit_ctrl[0] && op == OP_WR;
  assign wr_plain1 = wr_acc && hit_ctrl[1] && op == OP_WR;

  // helper strobes for the checks below
  wire [NUM_FILT-1:0] lane_hit;
  wire stat_clr0;
  wire stat_clr1;
  wire rd_stat;
  assign stat_clr0 = wr_acc && hit_stat && byteenable[1] && writedata[STAT_BLK_LSB];
  assign stat_clr1 = wr_acc && hit_stat && byteenable[1] && writedata[STAT_BLK_LSB+1];
  assign rd_stat = read && ack_r && hit_stat;

  // cycles spent waiting, so the answer time is bounded without a long repetition
  logic [1:0] wait_cnt_r;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wait_cnt_r <= 2'h0;
    end else if (waitrequest) begin
      wait_cnt_r <= wait_cnt_r + 2'h1;
    end else begin
      wait_cnt_r <= 2'h0;
    end
  end

  AST_BUS_ONE_WAIT: assert property ( // RQ15
    (req && waitrequest) |=> (!waitrequest && $stable(address)) or !req)
    else $error("access not answered after one wait cycle");

  AST_F11_LAYOUT: assert property ( // RQ2
    (wr_plain0 && byteenable[3] && !filt_cfg[3].on)
    |=> filt_cfg[3] == $past(writedata[31:24]))
    else $error("filter 11 byte not stored from bits 31-24");

  AST_F8_LAYOUT: assert property ( // RQ3
    (wr_plain0 && byteenable[0] && !filt_cfg[0].on)
    |=> filt_cfg[0].mask_choice == $past(writedata[6:5])
        && filt_cfg[0].dest_fifo_choice == $past(writedata[4:0]))
    else $error("filter 8 fields not stored from bits 6-0");

  AST_WORD1_READ: assert property ( // RQ4
    (read && ack_r && hit_ctrl[1] && op == OP_WR)
    |-> readdata == {filt_cfg[7], filt_cfg[6], filt_cfg[5], filt_cfg[4]})
    else $error("second word read does not match filters 15-12");

  AST_WORD0_READ: assert property ( // RQ8
    (read && ack_r && hit_ctrl[0] && op == OP_WR)
    |-> readdata == {filt_cfg[3], filt_cfg[2], filt_cfg[1], filt_cfg[0]})
    else $error("first word read does not match filters 11-8");

  AST_ENABLE_ALWAYS: assert property ( // RQ14
    (wr_plain1 && byteenable[0]) |=> filt_cfg[4].on == $past(writedata[ON_BIT]))
    else $error("enable of filter 12 not written");

  AST_CLR_ALIAS: assert property ( // RQ9
    (wr_acc && hit_ctrl[0] && op == OP_CLR && byteenable[1])
    |=> filt_cfg[1].on == ($past(filt_cfg[1].on) & ~$past(writedata[15])))
    else $error("clear alias wrong on filter 9 enable");

  AST_SET_ALIAS: assert property ( // RQ10
    (wr_acc && hit_ctrl[1] && op == OP_SET && byteenable[2])
    |=> filt_cfg[6].on == ($past(filt_cfg[6].on) | $past(writedata[23])))
    else $error("set alias wrong on filter 14 enable");

  AST_INV_ALIAS: assert property ( // RQ11
    (wr_acc && hit_ctrl[1] && op == OP_INV && byteenable[3])
    |=> filt_cfg[7].on == ($past(filt_cfg[7].on) ^ $past(writedata[31])))
    else $error("invert alias wrong on filter 15 enable");

  AST_LOCK_HOLDS: assert property ( // RQ13
    filt_cfg[5].on |=> filt_cfg[5][ON_BIT-1:0] == $past(filt_cfg[5][ON_BIT-1:0]))
    else $error("fields of enabled filter 13 changed");

  AST_BLOCK_FLAG: assert property ( // RQ13
    blocked[2] |=> blk_r[0] [*2] or (blk_r[0] ##1 !blk_r[0]))
    else $error("blocked change not flagged");

  AST_OFF_NO_MATCH: assert property ( // RQ5
    $fell(filt_cfg[2].on) |-> $past(wr_acc && hit_ctrl[0] && byteenable[2]))
    else $error("filter 10 turned off without a write");

  // remaining byte positions of the first word, written from disabled
  AST_F10_LAYOUT: assert property ( // RQ3
    (wr_plain0 && byteenable[2] && !filt_cfg[2].on)
    |=> filt_cfg[2] == $past(writedata[23:16]))
    else $error("filter 10 byte not stored from bits 23-16");

  AST_F9_LAYOUT: assert property ( // RQ3
    (wr_plain0 && byteenable[1] && !filt_cfg[1].on)
    |=> filt_cfg[1] == $past(writedata[15:8]))
    else $error("filter 9 byte not stored from bits 15-8");

  // second word, top and bottom byte
  AST_F15_LAYOUT: assert property ( // RQ4
    (wr_plain1 && byteenable[3] && !filt_cfg[7].on)
    |=> filt_cfg[7] == $past(writedata[31:24]))
    else $error("filter 15 byte not stored from bits 31-24");

  AST_F12_LAYOUT: assert property ( // RQ4
    (wr_plain1 && byteenable[0] && !filt_cfg[4].on)
    |=> filt_cfg[4] == $past(writedata[7:0]))
    else $error("filter 12 byte not stored from bits 7-0");

  // mask choice and fifo choice land in their own fields
  AST_MASK_FIELD: assert property ( // RQ6
    (wr_plain1 && byteenable[2] && !filt_cfg[6].on)
    |=> filt_cfg[6].mask_choice == $past(writedata[22:21]))
    else $error("filter 14 mask choice not stored from bits 22-21");

  AST_FIFO_FIELD: assert property ( // RQ7
    (wr_plain1 && byteenable[1] && !filt_cfg[5].on)
    |=> filt_cfg[5].dest_fifo_choice == $past(writedata[12:8]))
    else $error("filter 13 fifo choice not stored from bits 12-8");

  // alias writes on a disabled filter reach every bit of its byte
  AST_CLR_BYTE: assert property ( // RQ9
    (wr_acc && hit_ctrl[0] && op == OP_CLR && byteenable[0] && !filt_cfg[0].on)
    |=> filt_cfg[0] == ($past(filt_cfg[0]) & ~$past(writedata[7:0])))
    else $error("clear alias wrong on filter 8 byte");

  AST_SET_BYTE: assert property ( // RQ10
    (wr_acc && hit_ctrl[1] && op == OP_SET && byteenable[1] && !filt_cfg[5].on)
    |=> filt_cfg[5] == ($past(filt_cfg[5]) | $past(writedata[15:8])))
    else $error("set alias wrong on filter 13 byte");

  AST_INV_BYTE: assert property ( // RQ11
    (wr_acc && hit_ctrl[0] && op == OP_INV && byteenable[2] && !filt_cfg[2].on)
    |=> filt_cfg[2] == ($past(filt_cfg[2]) ^ $past(writedata[23:16])))
    else $error("invert alias wrong on filter 10 byte");

  // status read shows every enable, filter 15 on top
  AST_STAT_ON: assert property ( // RQ5
    rd_stat |-> readdata[NUM_FILT-1:0] == {filt_cfg[7].on, filt_cfg[6].on, filt_cfg[5].on, filt_cfg[4].on,
                                          filt_cfg[3].on, filt_cfg[2].on, filt_cfg[1].on, filt_cfg[0].on})
    else $error("status enable bits do not match the filters");

  // a write of one clears a flag; only a write of one may clear it
  AST_BLOCK_CLEAR: assert property ( // RQ13
    (stat_clr0 && !(|blocked[LANES-1:0])) |=> !blk_r[0])
    else $error("blocked flag of the first word not cleared");

  AST_BLOCK_KEEP: assert property ( // RQ13
    (blk_r[1] && !stat_clr1) |=> blk_r[1])
    else $error("blocked flag of the second word lost");

  // second word flags its own blocked changes
  AST_BLOCK_SET2: assert property ( // RQ13
    blocked[6] |=> blk_r[1])
    else $error("blocked change on filter 14 not flagged");

  // no wait is shown while the bus is idle
  AST_IDLE_NO_WAIT: assert property ( // RQ8
    !(read || write) |-> !waitrequest)
    else $error("waitrequest raised with no request");

  // a write must not disturb read data a slow master has not yet used
  AST_WR_KEEPS_RDATA: assert property ( // RQ8
    write |=> $stable(readdata))
    else $error("read data changed by a write");

  // every access is answered after a single wait cycle
  AST_WAIT_BOUND: assert property ( // RQ15
    wait_cnt_r <= 2'h1)
    else $error("request waited more than one cycle");

  // the same checks for every filter
  genvar g;
  generate
    for (g = 0; g < NUM_FILT; g++) begin : g_chk
      assign lane_hit[g] = wr_acc && hit_ctrl[g / LANES] && byteenable[g % LANES];

      AST_LANE_GATED: assert property ( // RQ1
        !lane_hit[g] |=> $stable(filt_cfg[g]))
        else $error("filter byte changed without a write to its lane");

      AST_LOCK_EACH: assert property ( // RQ13
        filt_cfg[g].on |=> filt_cfg[g][ON_BIT-1:0] == $past(filt_cfg[g][ON_BIT-1:0]))
        else $error("mask or fifo choice of an enabled filter changed");

      AST_ON_WRITABLE: assert property ( // RQ14
        (lane_hit[g] && op == OP_WR) |=> filt_cfg[g].on == $past(writedata[(g % LANES) * 8 + ON_BIT]))
        else $error("enable bit not taken from its lane");

      AST_FIELDS_FREE: assert property ( // RQ15
        (lane_hit[g] && op == OP_WR && !filt_cfg[g].on)
        |=> filt_cfg[g] == $past(writedata[(g % LANES) * 8 +: 8]))
        else $error("disabled filter byte not taken at the next edge");

      AST_FREE_NO_FLAG: assert property ( // RQ13
        (lane_hit[g] && !filt_cfg[g].on) |-> !blocked[g])
        else $error("write to a disabled filter reported as blocked");
    end
  endgenerate

  COV_PLAIN_WRITE: cover property (wr_plain0 && byteenable == 4'hF);
  COV_LOCK_BLOCK: cover property (blocked[0] ##1 blk_r[0]);
  COV_INV_ALIAS: cover property (wr_acc && hit_ctrl[1] && op == OP_INV);
  COV_REENABLE: cover property ($fell(filt_cfg[4].on) ##[1:20] $rose(filt_cfg[4].on));
  COV_FLAG_CLEAR: cover property (stat_clr0 ##1 !blk_r[0]);

endmodule : cfc_regs
`default_nettype wire

// ==== verification/can_filter_ctrl_8_to_15_tb.sv ====
// self-checking bench for the filter control register bank
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin errors++; $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module can_filter_ctrl_8_to_15_tb;
  import cfc_pkg::*;
  logic clock = 0, rst = 1, read = 0, write = 0;
  logic [ADDR_W-1:0] address = '0;
  logic [DATA_W-1:0] writedata = '0, readdata, q;
  logic [LANES-1:0] byteenable = '0;
  logic waitrequest;
  cfc_filt_t [NUM_FILT-1:0] filt_cfg;
  logic [31:0] m [2];
  logic [1:0] blk;
  logic [31:0] rs = 32'h93FA;
  logic [31:0] r;
  int errors = 0, num_checks = 0, cyc = 0;
  cfc_regs dut (.clock(clock), .rst(rst), .address(address), .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest), .filt_cfg(filt_cfg));
  always #10 clock = ~clock;
  // hang guard, far above the one to two thousand cycles the tests need
  always @(posedge clock) begin
    cyc++;
    if (cyc > 20000) begin
      errors++;
      report_and_stop();
    end
  end
  function automatic logic [31:0] xs();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction : xs
  // one avalon access; an idle edge first so strobes never toggle twice in a step
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d, input logic [3:0] be);
    @(posedge clock);
    write <= wr;
    read <= !wr;
    address <= a;
    writedata <= d;
    byteenable <= be;
    do @(posedge clock); while (waitrequest !== 1'b0);
    q = readdata;
    write <= 1'b0;
    read <= 1'b0;
  endtask : bus
  // write, update the model, then compare all eight filter outputs
  task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [3:0] be);
    logic [7:0] o, n;
    bus(1'b1, a, d, be);
    if (a < 6'h20 && a[1:0] == 2'b00) begin
      for (int l = 0; l < 4; l++) begin
        if (be[l]) begin
          o = m[a[4]][8*l+:8];
          n = d[8*l+:8];
          case (a[3:2])
            2'b01: n = o & ~n;
            2'b10: n = o | n;
            2'b11: n = o ^ n;
            default: ;
          endcase
          if (o[7] && n[6:0] != o[6:0]) begin
            blk[a[4]] = 1'b1;
            n[6:0] = o[6:0];
          end
          m[a[4]][8*l+:8] = n;
        end
      end
    end else if (a == OFS_STATUS && be[1]) blk &= ~d[9:8];
    @(posedge clock);
    for (int i = 0; i < 8; i++) `CHK(filt_cfg[i], m[i/4][8*(i%4)+:8])
  endtask : wr
  // read and compare; alias, misaligned and unmapped places read zero
  task automatic rd(input logic [5:0] a);
    logic [31:0] e;
    bus(1'b0, a, 32'h0, 4'hF);
    e = a == 6'h00 ? m[0] : a == 6'h10 ? m[1] : 32'h0;
    if (a == OFS_STATUS) e = {22'h0, blk, m[1][31], m[1][23], m[1][15], m[1][7], m[0][31], m[0][23], m[0][15], m[0][7]};
    `CHK(q, e)
  endtask : rd
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop
  initial begin
    m[0] = 32'h0;
    m[1] = 32'h0;
    blk = 2'b00;
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    // reset values
    for (int i = 0; i < 8; i++) `CHK(filt_cfg[i], FILT_RESET)
    rd(6'h00);
    rd(6'h10);
    rd(6'h20);
    $display("test reset done");
    // every mask code, fifo 31 and 0, highest filter in the top byte
    wr(6'h00, 32'h1F3F5F7F, 4'hF);
    wr(6'h10, 32'h60402000, 4'hF);
    `CHK(filt_cfg[3].mask_choice, 2'h0)
    `CHK(filt_cfg[3].dest_fifo_choice, 5'h1F)
    `CHK(filt_cfg[0].mask_choice, 2'h3)
    `CHK(filt_cfg[7].mask_choice, 2'h3)
    `CHK(filt_cfg[4].dest_fifo_choice, 5'h00)
    rd(6'h00);
    rd(6'h10);
    $display("test layout done");
    // each alias on both words, base read back, alias read as zero
    for (int w = 0; w < 2; w++) begin
      for (int op = 1; op < 4; op++) begin
        wr({1'b0, w[0], op[1:0], 2'b00}, xs(), 4'hF);
        rd({1'b0, w[0], 4'h0});
        rd({1'b0, w[0], op[1:0], 2'b00});
      end
    end
    $display("test alias done");
    // lock: off, enable with fields, blocked change, clear flag, clear-disable, rewrite
    wr(6'h00, 32'h0, 4'hF);
    wr(6'h00, 32'h8A8B8C8D, 4'hF);
    wr(6'h00, 32'h81818181, 4'hF);
    rd(6'h20);
    wr(6'h20, 32'h300, 4'h2);
    rd(6'h20);
    wr(6'h04, 32'h80808080, 4'hF);
    wr(6'h00, 32'h01020304, 4'hF);
    rd(6'h00);
    $display("test lock done");
    // random traffic, partial lanes, status, misaligned and unmapped places
    repeat (300) begin
      r = xs();
      if (r[8]) wr({r[5:2], (r[6] & r[7]) ? r[1:0] : 2'b00}, xs(), r[12:9]);
      else rd({r[5:2], (r[6] & r[7]) ? r[1:0] : 2'b00});
    end
    $display("test random done");
    // second reset in mid-run, then the bank must work again from all off
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    m[0] = 32'h0;
    m[1] = 32'h0;
    blk = 2'b00;
    for (int i = 0; i < 8; i++) `CHK(filt_cfg[i], FILT_RESET)
    rd(6'h20);
    wr(6'h10, xs(), 4'hF);
    rd(6'h10);
    $display("test reset again done");
    report_and_stop();
  end
endmodule : can_filter_ctrl_8_to_15_tb
`default_nettype wire
